//--- bench/hsc_config_regs_bench.sv
// Self-checking bench for the sensor configuration and serial registers.
`timescale 1ns/1ns
`default_nettype none
module hsc_config_regs_bench;
    import hsc_pkg::*;
    // Arbitrary identifier value for this bench.
    localparam logic [UID_W-1:0] UID = 41'h13579BDF24;
    localparam logic [6:0] ADDR = 7'h40;
    logic clk = 1'b0;
    logic rst_n;
    logic supply_low = 1'b0;
    logic conv_done = 1'b0;
    logic scl_clk, sda_pull, sda_out, sda_oe, heater_on, conv_temp_go, conv_hum_go;
    logic conv_busy, soft_reset_pulse;
    logic [3:0] conv_res_bits;
    logic [3:0] go_res;
    wire logic sda_line;
    int error_cnt = 0;
    int samples_checked = 0;
    int temp_cnt = 0;
    int hum_cnt = 0;
    int srst_cnt = 0;

    // Open-drain wire with a pull-up: low whenever either party pulls it.
    assign sda_line = ~(sda_pull | (sda_oe & ~sda_out));
    always #5 clk = ~clk;

    hsc_host i_hsc_host (.scl_clk(scl_clk), .sda_pull(sda_pull), .sda_line(sda_line));
    hsc_config_regs #(.DEV_ADDR(ADDR), .UNIQUE_ID(UID)) i_hsc_config_regs (
        .clk(clk), .rst_n(rst_n), .scl_clk(scl_clk), .sda_in(sda_line),
        .supply_low(supply_low), .conv_done(conv_done), .sda_out(sda_out),
        .sda_oe(sda_oe), .heater_on(heater_on), .conv_temp_go(conv_temp_go),
        .conv_hum_go(conv_hum_go), .conv_res_bits(conv_res_bits),
        .conv_busy(conv_busy), .soft_reset_pulse(soft_reset_pulse)
    );

    always @(posedge clk) begin
        if (conv_temp_go === 1'b1) begin
            temp_cnt++;
            go_res = conv_res_bits;
        end
        if (conv_hum_go === 1'b1) begin
            hum_cnt++;
            go_res = conv_res_bits;
        end
        if (soft_reset_pulse === 1'b1) begin
            srst_cnt++;
        end
    end

    task automatic final_report();
        $display("checks=%0d errors=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // Counters move on the rising edge, so they are read on the falling one.
    task automatic wait_go(input int n);
        int k = 0;
        while (temp_cnt + hum_cnt < n && k < 2000) begin
            @(negedge clk);
            k++;
        end
        if (k >= 2000) begin
            error_cnt++;
            final_report();
        end
    endtask

    task automatic wr_reg(input logic [7:0] ptr, input logic [15:0] d, input logic full);
        logic a;
        i_hsc_host.start_frame();
        i_hsc_host.put_byte({ADDR, 1'b0}, a);
        check(16'(a), 16'h0001);
        i_hsc_host.put_byte(ptr, a);
        if (full) begin
            i_hsc_host.put_byte(d[15:8], a);
            i_hsc_host.put_byte(d[7:0], a);
        end
        i_hsc_host.stop_frame();
    endtask

    // The pointer is always loaded in a frame of its own before the read.
    task automatic rd_reg(input logic [7:0] ptr, input logic [15:0] exp);
        logic a;
        logic [15:0] d;
        wr_reg(ptr, 16'h0000, 1'b0);
        i_hsc_host.start_frame();
        i_hsc_host.put_byte({ADDR, 1'b1}, a);
        check(16'(a), 16'h0001);
        i_hsc_host.get_byte(1'b1, d[15:8]);
        i_hsc_host.get_byte(1'b0, d[7:0]);
        i_hsc_host.stop_frame();
        check(d, exp);
    endtask

    task automatic pulse_done();
        @(posedge clk);
        conv_done <= 1'b1;
        @(posedge clk);
        conv_done <= 1'b0;
    endtask

    task automatic run_conv(input logic [7:0] ptr, input logic two, input logic [3:0] r1,
                            input logic [3:0] r2);
        int t0 = temp_cnt;
        int h0 = hum_cnt;
        wr_reg(ptr, 16'h0000, 1'b0);
        wait_go(t0 + h0 + 1);
        check(16'(go_res), 16'(r1));
        check(16'(conv_busy), 16'h0001);
        check(16'(hum_cnt - h0), 16'(ptr == PTR_HUM));
        pulse_done();
        if (two) begin
            wait_go(t0 + h0 + 2);
            check(16'(go_res), 16'(r2));
            pulse_done();
        end
        repeat (8) @(negedge clk);
        check(16'(conv_busy), 16'h0000);
        check(16'(temp_cnt - t0), 16'(ptr == PTR_TEMP));
        check(16'(hum_cnt - h0), 16'(ptr == PTR_HUM || two));
    endtask

    task automatic t_reset_and_refuse();
        logic a;
        logic [15:0] idle_w;
        idle_w = {6'h00, sda_out, soft_reset_pulse, conv_temp_go, conv_hum_go, heater_on,
                  conv_busy, conv_res_bits};
        check(idle_w, 16'h000E);
        i_hsc_host.start_frame();
        i_hsc_host.put_byte({ADDR + 7'h01, 1'b0}, a);
        i_hsc_host.stop_frame();
        check(16'(a), 16'h0000);
    endtask

    // Reserved bits are always written as zero from here on.
    task automatic t_config();
        wr_reg(PTR_CFG, 16'h3D00, 1'b1);
        check(16'(heater_on), 16'h0001);
        rd_reg(PTR_CFG, 16'h3500);
        @(posedge clk);
        supply_low <= 1'b1;
        rd_reg(PTR_CFG, 16'h3D00);
        @(posedge clk);
        supply_low <= 1'b0;
        wr_reg(PTR_CFG, 16'h0000, 1'b1);
        check(16'(heater_on), 16'h0000);
    endtask

    task automatic t_serial();
        wr_reg(PTR_UID_HI, 16'hFFFF, 1'b1);
        rd_reg(PTR_UID_HI, UID[40:25]);
        wr_reg(PTR_UID_MID, 16'h0000, 1'b1);
        rd_reg(PTR_UID_MID, UID[24:9]);
        rd_reg(PTR_UID_HI, UID[40:25]);
    endtask

    task automatic t_conversions();
        wr_reg(PTR_CFG, 16'h0400, 1'b1);
        run_conv(PTR_TEMP, 1'b0, 4'hB, 4'h0);
        wr_reg(PTR_CFG, 16'h0000, 1'b1);
        run_conv(PTR_TEMP, 1'b0, 4'hE, 4'h0);
        for (int c = 0; c < 3; c++) begin
            wr_reg(PTR_CFG, {6'h00, 2'(c), 8'h00}, 1'b1);
            run_conv(PTR_HUM, 1'b0, (c == 0) ? 4'hE : ((c == 1) ? 4'hB : 4'h8), 4'h0);
        end
        wr_reg(PTR_CFG, 16'h1600, 1'b1);
        run_conv(PTR_TEMP, 1'b1, 4'hB, 4'h8);
    endtask

    task automatic t_soft_reset();
        wr_reg(PTR_CFG, 16'h2000, 1'b1);
        check(16'(srst_cnt), 16'h0000);
        wr_reg(PTR_CFG, 16'h8000, 1'b1);
        check(16'(srst_cnt), 16'h0001);
        check(16'(heater_on), 16'h0000);
        rd_reg(PTR_CFG, 16'h0000);
    endtask

    // A reset in mid-run must clear the configuration just as the first one does.
    task automatic t_mid_reset();
        wr_reg(PTR_CFG, 16'h3000, 1'b1);
        check(16'(heater_on), 16'h0001);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        check(16'(heater_on), 16'h0000);
        rd_reg(PTR_CFG, 16'h0000);
    endtask

    initial begin
        // Driven at time zero so that every asynchronous reset sees a falling edge.
        rst_n <= 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        t_reset_and_refuse();
        t_config();
        t_serial();
        t_conversions();
        t_soft_reset();
        t_mid_reset();
        final_report();
    end
endmodule // hsc_config_regs_bench
`default_nettype wire

//--- bench/hsc_host.sv
// Behavioural two-wire host that makes the bus clock and pulls the data wire.
`timescale 1ns/1ns
`default_nettype none
module hsc_host (
    output logic scl_clk,
    output logic sda_pull,
    input wire logic sda_line
);
    // The bus clock stands high between frames, where the pull-up leaves it.
    initial begin
        scl_clk = 1'b1;
        sda_pull = 1'b0;
    end

    // Data moves only while the clock is low, so no bit looks like a start.
    task automatic clock_bit(input logic b, output logic seen);
        #16 sda_pull = ~b;
        #16 scl_clk = 1'b1;
        #16 seen = sda_line;
        #16 scl_clk = 1'b0;
    endtask

    task automatic start_frame();
        #3 sda_pull = 1'b1;
        #32 scl_clk = 1'b0;
    endtask

    task automatic stop_frame();
        #16 sda_pull = 1'b1;
        #16 scl_clk = 1'b1;
        #32 sda_pull = 1'b0;
        #32;
    endtask

    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(b[i], s);
        end
        clock_bit(1'b1, s);
        ack = ~s;
    endtask

    task automatic get_byte(input logic give_ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'b1, s);
            b[i] = s;
        end
        clock_bit(~give_ack, s);
    endtask
endmodule // hsc_host
`default_nettype wire

//--- rtl/hsc_config_regs.sv
// Configuration and serial registers of the humidity sensor behind its two-wire bus.
//
// Contract
// R1: Mode 0 converts only the quantity chosen by the pointer per trigger.
// R2: Mode 1 converts temperature, then humidity, on one trigger.
// R3: Bit 11 reads the supply-low flag; writes to it do nothing.
// R4: Bit 13 switches the on-chip heater on or off.
// R5: Bit 10 picks 14 or 11 bit temperature conversion.
// R6: Bits 9 to 8 pick 14, 11 or 8 bit humidity conversion.
// R7: A fixed unique identifier is held in read-only serial words.
// R8: Pointer 0xFB reads identifier bits 40 down to 25.
// R9: Pointer 0xFC reads identifier bits 24 down to 9.
// R10: Each bus write loads the 8-bit pointer; reads return the selected register.
// R11: The pointer leaves reset at 0x00.
// R12: Writing bit 15 resets the configuration and the bit clears itself.
// R13: Host writes zero to reserved bits and avoids humidity code 11.
// R14: Writes to the serial words are ignored.
`timescale 1ns/1ns
`default_nettype none
module hsc_config_regs #(
    parameter logic [6:0] DEV_ADDR = 7'h40,
    // Arbitrary identifier value; each part would be strapped with its own.
    parameter logic [hsc_pkg::UID_W-1:0] UNIQUE_ID = 41'h5A5AC3C396
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl_clk,
    input wire logic sda_in,
    input wire logic supply_low,
    input wire logic conv_done,
    output logic sda_out,
    output logic sda_oe,
    output logic heater_on,
    output logic conv_temp_go,
    output logic conv_hum_go,
    output logic [3:0] conv_res_bits,
    output logic conv_busy,
    output logic soft_reset_pulse
);
    import hsc_pkg::*;

    logic link_ptr_tgl;
    logic [7:0] link_ptr_byte;
    logic link_wr_tgl;
    logic [15:0] link_wr_word;
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    logic [1:0] tgl_d_reg;
    logic ptr_ev;
    logic wr_ev;
    logic supply_low_s;
    logic [7:0] ptr_reg;
    logic mode_both_reg;
    logic tres_reg;
    logic [1:0] hres_reg;
    logic [15:0] rd_word_reg;
    logic trig;
    logic cfg_wr;
    hsc_conv_state_t state_reg;

    function automatic logic [3:0] res_bits(input logic is_hum, input logic tres,
                                             input logic [1:0] hres);
        if (!is_hum) begin
            res_bits = tres ? RES_BITS_11 : RES_BITS_14;
        end else begin
            case (hres)
                HRES_11: res_bits = RES_BITS_11;
                HRES_8: res_bits = RES_BITS_8;
                default: res_bits = RES_BITS_14;
            endcase
        end
    endfunction

    function automatic logic [15:0] read_word(input logic [7:0] ptr, input logic heat,
                                              input logic both, input logic low,
                                              input logic tres, input logic [1:0] hres);
        logic [15:0] w;
        w = 16'h0000;
        case (ptr)
            PTR_CFG: begin
                w[CFG_HEATER_BIT] = heat;
                w[CFG_MODE_BIT] = both;
                w[CFG_SUPPLY_BIT] = low;
                w[CFG_TRES_BIT] = tres;
                w[CFG_HRES_LSB +: 2] = hres;
            end
            PTR_UID_HI: w = UNIQUE_ID[UID_HI_LSB +: 16];
            PTR_UID_MID: w = UNIQUE_ID[UID_MID_LSB +: 16];
            default: w = 16'h0000;
        endcase
        read_word = w;
    endfunction

    hsc_link #(
        .DEV_ADDR(DEV_ADDR)
    ) u_link (
        .scl_clk(scl_clk),
        .rst_n(rst_n),
        .sda_in(sda_in),
        .rd_word(rd_word_reg),
        .ptr_tgl(link_ptr_tgl),
        .ptr_byte(link_ptr_byte),
        .wr_tgl(link_wr_tgl),
        .wr_word(link_wr_word),
        .sda_oe(sda_oe)
    );

    // Toggles and the supply pin are synchronised; the data they announce is already stable.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
            tgl_d_reg <= 2'h0;
        end else begin
            sync1_reg <= {supply_low, link_wr_tgl, link_ptr_tgl};
            sync2_reg <= sync1_reg;
            tgl_d_reg <= sync2_reg[1:0];
        end
    end

    assign ptr_ev = sync2_reg[0] ^ tgl_d_reg[0];
    assign wr_ev = sync2_reg[1] ^ tgl_d_reg[1];
    assign supply_low_s = sync2_reg[2];
    assign cfg_wr = wr_ev && (ptr_reg == PTR_CFG); // R14
    assign trig = ptr_ev && (state_reg == ST_IDLE) &&
                  (link_ptr_byte == PTR_TEMP || link_ptr_byte == PTR_HUM);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr_reg <= PTR_RESET; // R11
        end else if (ptr_ev) begin
            ptr_reg <= link_ptr_byte; // R10
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            heater_on <= CFG_HEATER_RESET;
            mode_both_reg <= CFG_MODE_RESET;
            tres_reg <= CFG_TRES_RESET;
            hres_reg <= CFG_HRES_RESET;
            soft_reset_pulse <= 1'b0;
        end else begin
            soft_reset_pulse <= cfg_wr && link_wr_word[CFG_SWRST_BIT]; // R12
            if (cfg_wr && link_wr_word[CFG_SWRST_BIT]) begin
                heater_on <= CFG_HEATER_RESET; // R12
                mode_both_reg <= CFG_MODE_RESET;
                tres_reg <= CFG_TRES_RESET;
                hres_reg <= CFG_HRES_RESET;
            end else if (cfg_wr) begin
                heater_on <= link_wr_word[CFG_HEATER_BIT]; // R4
                mode_both_reg <= link_wr_word[CFG_MODE_BIT];
                tres_reg <= link_wr_word[CFG_TRES_BIT]; // R5
                hres_reg <= link_wr_word[CFG_HRES_LSB +: 2]; // R6
            end
        end
    end

    // The read word is refreshed every cycle so a bus read sees the current selection.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_word_reg <= 16'h0000;
            sda_out <= 1'b0;
        end else begin
            rd_word_reg <= read_word(ptr_reg, heater_on, mode_both_reg, supply_low_s,
                                     tres_reg, hres_reg); // R3 R7 R8 R9
            sda_out <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            conv_temp_go <= 1'b0;
            conv_hum_go <= 1'b0;
            conv_res_bits <= RES_BITS_14;
            conv_busy <= 1'b0;
        end else begin
            conv_temp_go <= 1'b0;
            conv_hum_go <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (trig && link_ptr_byte == PTR_TEMP) begin
                        state_reg <= ST_TEMP;
                        conv_temp_go <= 1'b1;
                        conv_res_bits <= res_bits(1'b0, tres_reg, hres_reg); // R5
                        conv_busy <= 1'b1;
                    end else if (trig) begin
                        state_reg <= ST_HUM; // R1
                        conv_hum_go <= 1'b1;
                        conv_res_bits <= res_bits(1'b1, tres_reg, hres_reg); // R6
                        conv_busy <= 1'b1;
                    end
                end
                ST_TEMP: begin
                    if (conv_done && mode_both_reg) begin
                        state_reg <= ST_HUM; // R2
                        conv_hum_go <= 1'b1;
                        conv_res_bits <= res_bits(1'b1, tres_reg, hres_reg);
                    end else if (conv_done) begin
                        state_reg <= ST_IDLE; // R1
                        conv_busy <= 1'b0;
                    end
                end
                ST_HUM: begin
                    if (conv_done) begin
                        state_reg <= ST_IDLE;
                        conv_busy <= 1'b0;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                    conv_busy <= 1'b0;
                end
            endcase
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    chk_single_temp: assert property ( // R1
        state_reg == ST_TEMP && conv_done && !mode_both_reg
        |=> state_reg == ST_IDLE && !conv_hum_go && !conv_busy)
        else $error("single mode started a second conversion");
    chk_both_sequence: assert property ( // R2
        state_reg == ST_TEMP && conv_done && mode_both_reg
        |=> conv_hum_go && state_reg == ST_HUM && conv_busy)
        else $error("dual mode did not follow with humidity");
    chk_supply_flag: assert property ( // R3
        ptr_reg == PTR_CFG && $stable(ptr_reg) |=> rd_word_reg[CFG_SUPPLY_BIT] == $past(supply_low_s))
        else $error("supply flag readback wrong");
    chk_heater_write: assert property ( // R4
        cfg_wr && !link_wr_word[CFG_SWRST_BIT]
        |=> heater_on == $past(link_wr_word[CFG_HEATER_BIT]) && !soft_reset_pulse)
        else $error("heater bit not taken from write");
    chk_temp_res: assert property ( // R5
        $rose(conv_temp_go) |-> conv_res_bits == (tres_reg ? RES_BITS_11 : RES_BITS_14))
        else $error("temperature resolution wrong");
    chk_hum_res: assert property ( // R6
        conv_hum_go && hres_reg == HRES_8 |-> conv_res_bits == RES_BITS_8)
        else $error("humidity resolution wrong");
    chk_uid_high: assert property ( // R8
        ptr_reg == PTR_UID_HI |=> rd_word_reg == UNIQUE_ID[40:25])
        else $error("high serial word wrong");
    chk_uid_mid: assert property ( // R9
        ptr_reg == PTR_UID_MID |=> rd_word_reg == UNIQUE_ID[24:9])
        else $error("middle serial word wrong");
    chk_ptr_load: assert property ( // R10
        ptr_ev |=> ptr_reg == $past(link_ptr_byte))
        else $error("pointer not loaded by write");
    // Checked during reset itself, so the default disable is overridden here.
    chk_ptr_reset: assert property (@(posedge clk) disable iff (1'b0) // R11
        !rst_n |-> ptr_reg == PTR_RESET)
        else $error("pointer not at reset value");
    chk_soft_reset: assert property ( // R12
        cfg_wr && link_wr_word[CFG_SWRST_BIT]
        |=> soft_reset_pulse && !heater_on && !mode_both_reg ##1 !soft_reset_pulse)
        else $error("software reset not self clearing");
    chk_serial_ro: assert property ( // R14
        wr_ev && ptr_reg != PTR_CFG |=> $stable(heater_on) && $stable(hres_reg) && $stable(tres_reg))
        else $error("write to read-only word changed state");

    cov_dual_conv: cover property (conv_temp_go ##[1:200] conv_hum_go);
    cov_cfg_write: cover property (cfg_wr && !link_wr_word[CFG_SWRST_BIT]);
    cov_uid_select: cover property (ptr_ev && link_ptr_byte == PTR_UID_HI);
    cov_soft_reset: cover property (soft_reset_pulse);
endmodule // hsc_config_regs
`default_nettype wire

//--- rtl/hsc_link.sv
// Two-wire bus slave that runs on the bus clock and hands pointer and word writes across.
`timescale 1ns/1ns
`default_nettype none
module hsc_link #(
    parameter logic [6:0] DEV_ADDR = 7'h40
) (
    input wire logic scl_clk,
    input wire logic rst_n,
    input wire logic sda_in,
    input wire logic [15:0] rd_word,
    output logic ptr_tgl,
    output logic [7:0] ptr_byte,
    output logic wr_tgl,
    output logic [15:0] wr_word,
    output logic sda_oe
);
    import hsc_pkg::*;

    logic start_tgl_reg;
    logic start_seen_reg;
    logic active_reg;
    logic rw_reg;
    logic ack_due_reg;
    logic [3:0] bit_cnt_reg;
    logic [2:0] byte_no_reg;
    logic [6:0] shift_reg;
    logic [7:0] data_hi_reg;
    logic [15:0] tx_word_reg;
    logic [7:0] rx_byte;
    logic [7:0] tx_byte;
    logic new_start;

    // A falling data line while the clock is high marks a start, also a repeated one.
    always_ff @(negedge sda_in or negedge rst_n) begin
        if (!rst_n) begin
            start_tgl_reg <= 1'b0;
        end else if (scl_clk) begin
            start_tgl_reg <= ~start_tgl_reg;
        end
    end

    assign new_start = start_tgl_reg ^ start_seen_reg;
    assign rx_byte = {shift_reg, sda_in};

    always_comb begin
        case (byte_no_reg)
            BYTE_PTR: tx_byte = tx_word_reg[15:8];
            BYTE_DHI: tx_byte = tx_word_reg[7:0];
            default: tx_byte = 8'hFF;
        endcase
    end

    always_ff @(posedge scl_clk or negedge rst_n) begin
        if (!rst_n) begin
            start_seen_reg <= 1'b0;
            active_reg <= 1'b0;
            rw_reg <= 1'b0;
            ack_due_reg <= 1'b0;
            bit_cnt_reg <= 4'h0;
            byte_no_reg <= 3'h0;
            shift_reg <= 7'h00;
            data_hi_reg <= 8'h00;
            tx_word_reg <= 16'h0000;
            ptr_tgl <= 1'b0;
            ptr_byte <= 8'h00;
            wr_tgl <= 1'b0;
            wr_word <= 16'h0000;
        end else if (new_start) begin
            start_seen_reg <= start_tgl_reg;
            active_reg <= 1'b1;
            bit_cnt_reg <= 4'h1;
            byte_no_reg <= BYTE_ADDR;
            shift_reg <= {6'h00, sda_in};
        end else if (active_reg) begin
            if (bit_cnt_reg == ACK_BIT) begin
                bit_cnt_reg <= 4'h0;
                if (byte_no_reg != BYTE_LAST) begin
                    byte_no_reg <= byte_no_reg + 3'h1;
                end
                // A host that declines a read byte ends the transfer.
                if (rw_reg && byte_no_reg != BYTE_ADDR && sda_in) begin
                    active_reg <= 1'b0;
                end
            end else begin
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                shift_reg <= rx_byte[6:0];
            end
            if (bit_cnt_reg == 4'h7) begin
                ack_due_reg <= (byte_no_reg == BYTE_ADDR) || !rw_reg;
                if (byte_no_reg == BYTE_ADDR) begin
                    rw_reg <= sda_in;
                    // The word is sampled here; it has stood still since the pointer write.
                    tx_word_reg <= rd_word;
                    if (rx_byte[7:1] != DEV_ADDR) begin
                        active_reg <= 1'b0;
                    end
                end else if (!rw_reg && byte_no_reg == BYTE_PTR) begin
                    ptr_byte <= rx_byte; // R10
                    ptr_tgl <= ~ptr_tgl; // R10
                end else if (!rw_reg && byte_no_reg == BYTE_DHI) begin
                    data_hi_reg <= rx_byte;
                end else if (!rw_reg && byte_no_reg == BYTE_DLO) begin
                    wr_word <= {data_hi_reg, rx_byte};
                    wr_tgl <= ~wr_tgl;
                end
            end
        end
    end

    // The line changes only while the clock is low, so it never fakes a start or stop.
    always_ff @(negedge scl_clk or negedge rst_n) begin
        if (!rst_n) begin
            sda_oe <= 1'b0;
        end else if (!active_reg) begin
            sda_oe <= 1'b0;
        end else if (bit_cnt_reg == ACK_BIT) begin
            sda_oe <= ack_due_reg;
        end else if (rw_reg && byte_no_reg != BYTE_ADDR) begin
            sda_oe <= ~tx_byte[3'(4'h7 - bit_cnt_reg)];
        end else begin
            sda_oe <= 1'b0;
        end
    end
endmodule // hsc_link
`default_nettype wire

//--- rtl/hsc_pkg.sv
// Shared constants and types of the humidity sensor configuration and serial registers.
package hsc_pkg;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [7:0] PTR_TEMP = 8'h00;
    localparam logic [7:0] PTR_HUM = 8'h01;
    localparam logic [7:0] PTR_CFG = 8'h02;
    localparam logic [7:0] PTR_UID_HI = 8'hFB;
    localparam logic [7:0] PTR_UID_MID = 8'hFC;
    localparam int CFG_SWRST_BIT = 15;
    localparam int CFG_HEATER_BIT = 13;
    localparam int CFG_MODE_BIT = 12;
    localparam int CFG_SUPPLY_BIT = 11;
    localparam int CFG_TRES_BIT = 10;
    localparam int CFG_HRES_LSB = 8;
    localparam logic CFG_HEATER_RESET = 1'b0;
    localparam logic CFG_MODE_RESET = 1'b0;
    localparam logic CFG_TRES_RESET = 1'b0;
    localparam logic [1:0] CFG_HRES_RESET = 2'h0;
    localparam int UID_W = 41;
    localparam int UID_HI_LSB = 25;
    localparam int UID_MID_LSB = 9;
    localparam logic [1:0] HRES_14 = 2'h0;
    localparam logic [1:0] HRES_11 = 2'h1;
    localparam logic [1:0] HRES_8 = 2'h2;
    localparam logic [3:0] RES_BITS_14 = 4'hE;
    localparam logic [3:0] RES_BITS_11 = 4'hB;
    localparam logic [3:0] RES_BITS_8 = 4'h8;
    localparam logic [3:0] ACK_BIT = 4'h8;
    localparam logic [2:0] BYTE_ADDR = 3'h0;
    localparam logic [2:0] BYTE_PTR = 3'h1;
    localparam logic [2:0] BYTE_DHI = 3'h2;
    localparam logic [2:0] BYTE_DLO = 3'h3;
    localparam logic [2:0] BYTE_LAST = 3'h4;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_TEMP = 2'h1,
        ST_HUM = 2'h3
    } hsc_conv_state_t;
endpackage
